// [sim/bs_receiver_model.sv]
// base station model: frame timing, burst ack and capture of ranging carriers
`timescale 1ns/1ns
module bs_receiver_model (
  // clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset,
  // bench commands
  input  wire logic                     i_fire,
  input  wire logic [3:0]               i_fire_num,
  input  wire logic                     i_slow,
  // air side
  input  wire ranging_pkg::rng_sample_t i_sample,
  input  wire logic                     i_burst_req,
  output logic                          o_sym_start,
  output logic [3:0]                    o_sym_num,
  output logic                          o_burst_ack
);
  import ranging_pkg::*;
  rng_sample_t cap [0:211];
  int          cnt;
  int          wait_cnt;
  always_ff @(posedge i_ref_clk) begin
    o_sym_start <= i_fire && !i_reset;
    // symbol number is only meaningful with the pulse, so it toggles otherwise
    o_sym_num   <= i_reset ? 4'h0 : (i_fire ? i_fire_num : ~o_sym_num);
    wait_cnt    <= (i_reset || !i_burst_req || o_burst_ack) ? 0 : wait_cnt + 1;
    o_burst_ack <= !i_reset && i_burst_req && !o_burst_ack && wait_cnt == (i_slow ? 6 : 0);
    // carriers logged in arrival order with their subchannel
    if (i_reset || i_fire) begin
      cnt <= 0;
    end else if (i_sample.valid && cnt < 212) begin
      cap[cnt] <= i_sample;
      cnt      <= cnt + 1;
    end
  end
endmodule

// [sim/ranging_tx_sva.sv]
// checker: port relations of the ranging code transmitter
`timescale 1ns/1ns
module ranging_tx_chk (
  // clock and reset
  input wire logic                     i_ref_clk,
  input wire logic                     i_reset,
  // observed ports
  input wire ranging_pkg::reg_req_t    i_reg,
  input wire ranging_pkg::sync_t       i_sync,
  input wire logic                     i_sym_start,
  input wire logic                     i_payload_req,
  input wire logic                     o_payload_en,
  input wire ranging_pkg::rng_sample_t o_sample,
  input wire logic                     o_phase_cont,
  input wire logic                     o_burst_req,
  input wire logic                     o_ext_header,
  input wire logic                     i_burst_ack,
  input wire logic                     o_timing_ok
);
  import ranging_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  property p_pay_grant;
    o_payload_en |-> $past((&i_sync) && i_payload_req);
  endproperty
  a_pay_grant: assert property (p_pay_grant) else $error("payload granted without sync");
  property p_pay_emit;
    o_sample.valid && $past(o_sample.valid) |-> !o_payload_en;
  endproperty
  a_pay_emit: assert property (p_pay_emit) else $error("payload granted while ranging");
  property p_phase;
    o_phase_cont == (o_sample.valid && o_sample.second);
  endproperty
  a_phase: assert property (p_phase) else $error("phase hold flag wrong");
  property p_ext;
    o_burst_req |-> o_ext_header;
  endproperty
  a_ext: assert property (p_ext) else $error("burst without extended header");
  property p_ack;
    o_burst_req && i_burst_ack |=> !o_burst_req;
  endproperty
  a_ack: assert property (p_ack) else $error("burst request outlived ack");
  property p_car_step;
    o_sample.valid && $past(o_sample.valid) && o_sample.carrier != 6'h0
      |-> o_sample.carrier == $past(o_sample.carrier) + 6'h1;
  endproperty
  a_car_step: assert property (p_car_step) else $error("carrier skipped");
  property p_car_rng;
    o_sample.valid |-> o_sample.carrier <= 6'h34;
  endproperty
  a_car_rng: assert property (p_car_rng) else $error("carrier beyond subchannel");
  property p_start;
    // the pulse is registered into the state, then into the sample
    $rose(o_sample.valid) |-> $past(i_sym_start, 2);
  endproperty
  a_start: assert property (p_start) else $error("emission without symbol start");
  property p_tok;
    $changed(o_timing_ok) |-> $past(i_reg.wr && i_reg.addr == OFF_OFFSET);
  endproperty
  a_tok: assert property (p_tok) else $error("timing flag moved without error");
endmodule

bind ranging_tx ranging_tx_chk i_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg(i_reg), .i_sync(i_sync),
  .i_sym_start(i_sym_start), .i_payload_req(i_payload_req), .o_payload_en(o_payload_en),
  .o_sample(o_sample), .o_phase_cont(o_phase_cont), .o_burst_req(o_burst_req),
  .o_ext_header(o_ext_header), .i_burst_ack(i_burst_ack), .o_timing_ok(o_timing_ok)
);

// [sim/testbench.sv]
// self-checking bench for the ranging code transmitter
`timescale 1ns/1ns
module testbench;
  import ranging_pkg::*;
  logic        ref_clk, reset, payload_req, payload_en, phase_cont, burst_req, ext_header;
  logic        burst_ack, timing_ok, sym_start, fire, slow;
  logic [3:0]  sym_num, fire_num;
  logic [31:0] rdata;
  logic [15:0] advance;
  reg_req_t    req;
  sync_t       sync;
  rng_sample_t sample;
  logic        seq [0:5299];
  logic [5:0]  lst [0:3];
  int          miscompares, checked, cycles;

  ranging_tx i_dut (.i_ref_clk(ref_clk), .i_reset(reset), .i_reg(req), .o_reg_rdata(rdata),
    .i_sync(sync), .i_sym_start(sym_start), .i_sym_num(sym_num), .i_payload_req(payload_req),
    .o_payload_en(payload_en), .o_sample(sample), .o_phase_cont(phase_cont),
    .o_burst_req(burst_req), .o_ext_header(ext_header), .i_burst_ack(burst_ack),
    .o_tx_advance(advance), .o_timing_ok(timing_ok));
  bs_receiver_model i_bs (.i_ref_clk(ref_clk), .i_reset(reset), .i_fire(fire),
    .i_fire_num(fire_num), .i_slow(slow), .i_sample(sample), .i_burst_req(burst_req),
    .o_sym_start(sym_start), .o_sym_num(sym_num), .o_burst_ack(burst_ack));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 chk(rdata & m, e, "register read");
  endtask
  // one symbol of emission, compared carrier by carrier against the reference sequence
  task automatic emit(input int sym, input int idx, input int n, input int ent, input logic sec);
    int k;
    k = 0;
    @(posedge ref_clk);
    fire     <= 1'b1;
    fire_num <= sym[3:0];
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (2) @(posedge ref_clk);
    while (i_bs.cnt < n && k < 400) begin
      @(posedge ref_clk);
      #1 if (sample.valid) chk(32'(phase_cont), 32'(sec), "phase hold flag");
      k++;
    end
    repeat (2) @(posedge ref_clk);
    chk(32'(i_bs.cnt), 32'(n), "carrier count");
    for (int i = 0; i < n; i++) begin
      chk(32'(i_bs.cap[i]), 32'({1'b1, seq[idx*106+i], sec, lst[n == 53 ? ent : i/53],
        6'(i % 53)}), "carrier");
    end
  endtask
  task automatic run_code(input logic [31:0] ctrl, input int sel, input int idx,
                          input int n, input int sym, input int ent);
    reg_wr(OFF_CODE, 32'(sel));
    reg_wr(OFF_CTRL, ctrl);
    rd_chk(OFF_STATUS, 32'h3f09, (32'(idx) << 8) | 32'h1);
    repeat (idx*106 + n + 4) @(posedge ref_clk);
    emit(sym, idx, n, ent, 1'b0);
    if (n == 106) emit(1, idx, n, ent, 1'b1);
    rd_chk(OFF_STATUS, 32'h19, 32'h10);
  endtask

  task automatic t_reset;
    rd_chk(OFF_ALLOC, 32'hffff_ffff, 32'h020c_2040);
    rd_chk(OFF_GUARD, 32'hffff, 32'h0040);
    rd_chk(OFF_STATUS, 32'h1f, 32'h0);
    rd_chk(8'h20, 32'hffff_ffff, 32'h0);
  endtask
  task automatic t_long;
    lst = '{6'h0, 6'h1, 6'h2, 6'h3};
    run_code(32'h3, 0, 0, 106, 0, 0);
    reg_wr(OFF_ALLOC, 32'h0200_0245);
    lst[0] = 6'h5;
    lst[1] = 6'h9;
    run_code(32'h3, 1, 1, 106, 0, 0);
  endtask
  task automatic t_refuse;
    logic [31:0] tbl [0:2];
    tbl = '{32'h13, 32'h06, 32'h20};
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      sync <= (i == 0) ? 4'h0 : 4'hf;
      reg_wr(OFF_SHORT, tbl[i]);
      reg_wr(OFF_CTRL, 32'h1);
      rd_chk(OFF_STATUS, 32'h9, 32'h8);
    end
    // five subchannels is more than the allocation can hold
    reg_wr(OFF_ALLOC, 32'h0500_0245);
    reg_wr(OFF_CTRL, 32'h3);
    rd_chk(OFF_STATUS, 32'h9, 32'h8);
    reg_wr(OFF_ALLOC, 32'h0200_0245);
  endtask
  task automatic t_short;
    // payload asked for while ranging: the grant must pause during emission
    @(posedge ref_clk);
    payload_req <= 1'b1;
    reg_wr(OFF_SHORT, 32'h13);
    run_code(32'h1, 2, 18, 53, 3, 1);
    reg_wr(OFF_SHORT, 32'h05);
    run_code(32'h5, 15, 47, 53, 5, 0);
  endtask
  task automatic t_payload;
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      sync        <= (i < 4) ? (4'hf ^ (4'h1 << i)) : 4'hf;
      payload_req <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 chk(32'(payload_en), 32'(i == 4), "payload gate");
    end
  endtask
  task automatic t_offset;
    reg_wr(OFF_OFFSET, 32'h0000_0013);
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, timing_ok}, 32'h1, "arrival within window");
    reg_wr(OFF_OFFSET, 32'h0000_ffec);
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, timing_ok}, 32'h0, "arrival outside window");
    chk({16'h0, advance}, 32'hffff, "accumulated advance");
  endtask
  task automatic t_ofdm;
    @(posedge ref_clk);
    slow <= 1'b1;
    reg_wr(OFF_CTRL, 32'h9);
    #1 chk({30'h0, burst_req, ext_header}, 32'h3, "burst pending");
    repeat (12) @(posedge ref_clk);
    #1 chk({30'h0, burst_req, ext_header}, 32'h0, "burst acknowledged");
  endtask

  initial begin
    logic [14:0] s;
    s = PRBS_SEED;
    for (int i = 0; i < 5300; i++) begin
      seq[i] = s[PRBS_TAP_A];
      s = {s[13:0], s[PRBS_TAP_A] ^ s[PRBS_TAP_B] ^ s[PRBS_TAP_C]};
    end
    req = '0;
    sync = '0;
    payload_req = 1'b0;
    fire = 1'b0;
    fire_num = 4'h0;
    slow = 1'b0;
    reset = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_long();
    t_refuse();
    t_short();
    t_payload();
    t_offset();
    t_ofdm();
    end_of_test();
  end
endmodule

// [verilog/ranging_pkg.sv]
// package: constants and types shared by the ranging code transmitter
package ranging_pkg;

  // code geometry
  localparam int SUB_BITS      = 53;
  localparam int MAX_SUB       = 4;
  localparam int MAX_LEN       = 212;
  localparam int CODES_PER_SET = 16;
  localparam int NUM_CODES     = 48;
  localparam int NUM_RNG_SYM   = 6;

  // sequence generator: 1 + x^4 + x^7 + x^15
  localparam int          PRBS_W     = 15;
  localparam int          PRBS_TAP_A = 14;
  localparam int          PRBS_TAP_B = 6;
  localparam int          PRBS_TAP_C = 3;
  localparam logic [14:0] PRBS_SEED  = 15'h5a3c;

  // frame symbols of a long ranging transmission
  localparam logic [3:0] LONG_SYM_FIRST  = 4'h0;
  localparam logic [3:0] LONG_SYM_SECOND = 4'h1;

  // arrival accuracy: percent of guard interval
  localparam logic [31:0] GUARD_PCT = 32'h0000_001e;
  localparam logic [31:0] PCT_SCALE = 32'h0000_0064;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CODE    = 8'h04;
  localparam logic [7:0] OFF_ALLOC   = 8'h08;
  localparam logic [7:0] OFF_SHORT   = 8'h0c;
  localparam logic [7:0] OFF_GUARD   = 8'h10;
  localparam logic [7:0] OFF_OFFSET  = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_ADVANCE = 8'h1c;

  // field positions
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_LONG_BIT  = 1;
  localparam int CTRL_BW_BIT    = 2;
  localparam int CTRL_OFDM_BIT  = 3;
  localparam int CODE_SEL_LSB   = 0;
  localparam int ALLOC_ENT_W    = 6;
  localparam int ALLOC_CNT_LSB  = 24;
  localparam int SHORT_SYM_LSB  = 0;
  localparam int SHORT_ENT_LSB  = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SYNC_BIT  = 1;
  localparam int STAT_TOK_BIT   = 2;
  localparam int STAT_REJ_BIT   = 3;
  localparam int STAT_DONE_BIT  = 4;
  localparam int STAT_CODE_LSB  = 8;

  // reset values
  localparam logic [2:0]  RST_NSUB  = 3'h2;
  localparam logic [15:0] RST_GUARD = 16'h0040;

  typedef enum logic [1:0] {SET_INITIAL, SET_MAINT, SET_BWREQ} code_set_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic timing;
    logic freq;
    logic frame;
    logic stamp;
  } sync_t;

  typedef struct packed {
    logic       valid;
    logic       neg;
    logic       second;
    logic [5:0] subch;
    logic [5:0] carrier;
  } rng_sample_t;

endpackage

// [verilog/ranging_prbs.sv]
// 15-stage ranging code sequence generator, one bit per step
`timescale 1ns/1ns
module ranging_prbs (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  // control
  input  wire logic i_restart,
  input  wire logic i_step,
  // sequence output
  output logic      o_bit
);
  import ranging_pkg::*;

  logic [PRBS_W-1:0] state_reg;
  wire               feedback;

  assign feedback = state_reg[PRBS_TAP_A] ^ state_reg[PRBS_TAP_B] ^ state_reg[PRBS_TAP_C];
  assign o_bit    = state_reg[PRBS_TAP_A];

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i_restart) begin
      state_reg <= PRBS_SEED;
    end else if (i_step) begin
      state_reg <= {state_reg[PRBS_W-2:0], feedback};
    end
  end
endmodule

// [verilog/ranging_tx.sv]
// ranging code generator and ranging transmission scheduler
`timescale 1ns/1ns
module ranging_tx (
  // clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset,
  // register port
  input  wire ranging_pkg::reg_req_t    i_reg,
  output logic [31:0]                   o_reg_rdata,
  // synchronisation state from the receiver
  input  wire ranging_pkg::sync_t       i_sync,
  // upstream frame timing
  input  wire logic                     i_sym_start,
  input  wire logic [3:0]               i_sym_num,
  // payload gate
  input  wire logic                     i_payload_req,
  output logic                          o_payload_en,
  // ranging carrier stream
  output ranging_pkg::rng_sample_t      o_sample,
  output logic                          o_phase_cont,
  // ofdm mapping burst request
  output logic                          o_burst_req,
  output logic                          o_ext_header,
  input  wire logic                     i_burst_ack,
  // transmit timing
  output logic signed [15:0]            o_tx_advance,
  output logic                          o_timing_ok
);
  import ranging_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SKIP, ST_LOAD, ST_WAIT, ST_EMIT, ST_BURST} state_t;

  // code length for a number of subchannels
  function automatic logic [7:0] code_len(input logic [2:0] nsub);
    code_len = 8'(SUB_BITS * int'(nsub));
  endfunction

  // absolute value of a signed error
  function automatic logic [31:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 32'(-int'(v)) : 32'(int'(v));
  endfunction

  // configuration registers
  logic                 long_reg;
  logic                 bw_reg;
  logic                 ofdm_reg;
  logic [3:0]           code_sel_reg;
  logic [2:0]           nsub_reg;
  logic [5:0]           sub_list_reg [MAX_SUB];
  logic [2:0]           short_sym_reg;
  logic [1:0]           short_ent_reg;
  logic [15:0]          guard_reg;
  // timing state
  logic signed [15:0]   advance_reg;
  logic signed [15:0]   err_reg;
  logic                 timing_ok_reg;
  // sequencer state
  state_t               state_reg;
  state_t               state_next;
  logic [5:0]           code_idx_reg;
  logic [13:0]          skip_reg;
  logic [7:0]           len_reg;
  logic [7:0]           bit_reg;
  logic [5:0]           carrier_reg;
  logic [1:0]           chunk_reg;
  logic                 pass_reg;
  logic [MAX_LEN-1:0]   code_reg;
  logic                 reject_reg;
  logic                 done_reg;
  rng_sample_t          sample_reg;
  logic                 payload_en_reg;
  logic [31:0]          rdata_reg;

  // register decode
  wire        wr_ctrl   = i_reg.wr && (i_reg.addr == OFF_CTRL);
  wire        wr_code   = i_reg.wr && (i_reg.addr == OFF_CODE);
  wire        wr_alloc  = i_reg.wr && (i_reg.addr == OFF_ALLOC);
  wire        wr_short  = i_reg.wr && (i_reg.addr == OFF_SHORT);
  wire        wr_guard  = i_reg.wr && (i_reg.addr == OFF_GUARD);
  wire        wr_offset = i_reg.wr && (i_reg.addr == OFF_OFFSET);
  wire        go        = wr_ctrl && i_reg.wdata[CTRL_GO_BIT];
  wire        req_long  = i_reg.wdata[CTRL_LONG_BIT];
  wire        req_bw    = i_reg.wdata[CTRL_BW_BIT];
  wire        req_ofdm  = i_reg.wdata[CTRL_OFDM_BIT];
  wire        busy      = (state_reg != ST_IDLE);

  wire        synced    = i_sync.timing & i_sync.freq & i_sync.frame & i_sync.stamp;

  wire        alloc_bad = (nsub_reg == 3'h0) || (nsub_reg > 3'(MAX_SUB));
  wire        short_bad = ({1'b0, short_ent_reg} >= nsub_reg) ||
                          (short_sym_reg >= 3'(NUM_RNG_SYM));

  wire        reject    = busy ||
                          (!req_ofdm && alloc_bad) ||
                          (!req_ofdm && !req_long && (!synced || short_bad));

  wire code_set_t go_set = req_long ? SET_INITIAL : (req_bw ? SET_BWREQ : SET_MAINT);

  wire [5:0]  go_idx    = {go_set, code_sel_reg};

  wire [7:0]  go_len    = req_long ? code_len(nsub_reg) : code_len(3'h1);
  wire [13:0] go_skip   = 14'(int'(go_idx) * int'(code_len(nsub_reg)));
  wire        go_accept = go && !reject;

  // sequence generator drive
  wire        prbs_bit;
  wire        prbs_step = (state_reg == ST_SKIP) || (state_reg == ST_LOAD);
  wire        last_bit  = (bit_reg == len_reg - 8'h01);
  wire        last_car  = (carrier_reg == 6'(SUB_BITS - 1));
  wire [3:0]  target    = long_reg ? (pass_reg ? LONG_SYM_SECOND : LONG_SYM_FIRST)
                                   : {1'b0, short_sym_reg};
  wire        sym_hit   = i_sym_start && (i_sym_num == target);

  wire [1:0]  ent_sel   = long_reg ? chunk_reg : short_ent_reg;

  ranging_prbs u_prbs (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_restart (go_accept),
    .i_step    (prbs_step),
    .o_bit     (prbs_bit)
  );

  // configuration
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      long_reg      <= 1'b0;
      bw_reg        <= 1'b0;
      ofdm_reg      <= 1'b0;
      code_sel_reg  <= 4'h0;
      nsub_reg      <= RST_NSUB;
      short_sym_reg <= 3'h0;
      short_ent_reg <= 2'h0;
      guard_reg     <= RST_GUARD;
    end else begin
      if (go_accept) begin
        long_reg <= req_long;
        bw_reg   <= req_bw;
        ofdm_reg <= req_ofdm;
      end
      if (wr_code) begin
        code_sel_reg <= i_reg.wdata[CODE_SEL_LSB +: 4];
      end
      // allocation frozen while a code is in flight
      if (wr_alloc && !busy) begin
        nsub_reg <= i_reg.wdata[ALLOC_CNT_LSB +: 3];
      end
      if (wr_short && !busy) begin
        short_sym_reg <= i_reg.wdata[SHORT_SYM_LSB +: 3];
        short_ent_reg <= i_reg.wdata[SHORT_ENT_LSB +: 2];
      end
      if (wr_guard) begin
        guard_reg <= i_reg.wdata[15:0];
      end
    end
  end

  // subchannel list
  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < MAX_SUB; i++) begin
      if (i_reset) begin
        sub_list_reg[i] <= 6'(i);
      end else if (wr_alloc && !busy) begin
        sub_list_reg[i] <= i_reg.wdata[i*ALLOC_ENT_W +: ALLOC_ENT_W];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      advance_reg   <= 16'sh0000;
      err_reg       <= 16'sh0000;
      timing_ok_reg <= 1'b0;
    end else if (wr_offset) begin
      err_reg       <= i_reg.wdata[15:0];
      advance_reg   <= advance_reg + $signed(i_reg.wdata[15:0]);
      timing_ok_reg <= (abs16(i_reg.wdata[15:0]) * PCT_SCALE) <=
                       (32'(guard_reg) * GUARD_PCT);
    end
  end

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  state_next = !go_accept ? ST_IDLE : (req_ofdm ? ST_BURST :
                             ((go_skip == 14'h0000) ? ST_LOAD : ST_SKIP));
      ST_SKIP:  state_next = (skip_reg == 14'h0001) ? ST_LOAD : ST_SKIP;
      ST_LOAD:  state_next = last_bit ? ST_WAIT : ST_LOAD;
      ST_WAIT:  state_next = sym_hit ? ST_EMIT : ST_WAIT;
      ST_EMIT:  state_next = !last_bit ? ST_EMIT : ((long_reg && !pass_reg) ? ST_WAIT : ST_IDLE);
      ST_BURST: state_next = i_burst_ack ? ST_IDLE : ST_BURST;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // code index, skip count and bit walk
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      code_idx_reg <= 6'h00;
      skip_reg     <= 14'h0000;
      len_reg      <= 8'h00;
      bit_reg      <= 8'h00;
      carrier_reg  <= 6'h00;
      chunk_reg    <= 2'h0;
      pass_reg     <= 1'b0;
    end else if (go_accept) begin
      code_idx_reg <= go_idx;
      // skip whole codes ahead of the chosen one
      skip_reg     <= go_skip;
      len_reg      <= go_len;
      bit_reg      <= 8'h00;
      pass_reg     <= 1'b0;
    end else begin
      case (state_reg)
        ST_SKIP: skip_reg <= skip_reg - 14'h0001;
        ST_LOAD: bit_reg <= last_bit ? 8'h00 : bit_reg + 8'h01;
        ST_WAIT: begin
          carrier_reg <= 6'h00;
          chunk_reg   <= 2'h0;
        end
        ST_EMIT: begin
          bit_reg     <= last_bit ? 8'h00 : bit_reg + 8'h01;
          carrier_reg <= last_car ? 6'h00 : carrier_reg + 6'h01;
          chunk_reg   <= last_car ? chunk_reg + 2'h1 : chunk_reg;
          if (last_bit) begin
            pass_reg <= 1'b1;
          end
        end
        default: pass_reg <= pass_reg;
      endcase
    end
  end

  // code capture; kept whole so the second long symbol repeats it exactly
  // one code per preamble
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      code_reg <= '0;
    end else if (state_reg == ST_LOAD) begin
      code_reg[bit_reg] <= prbs_bit;
    end
  end

  // carrier stream
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sample_reg <= '0;
    end else if (state_reg == ST_EMIT) begin
      sample_reg.valid   <= 1'b1;
      sample_reg.neg     <= code_reg[bit_reg];
      sample_reg.second  <= pass_reg;
      sample_reg.subch   <= sub_list_reg[ent_sel];
      sample_reg.carrier <= carrier_reg;
    end else begin
      sample_reg <= '0;
    end
  end

  // status flags
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      reject_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else if (go) begin
      reject_reg <= reject;
      // a refused go must not hide a code that finishes in the same cycle
      done_reg   <= busy && (state_next == ST_IDLE);
    end else if (busy && state_next == ST_IDLE) begin
      done_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      payload_en_reg <= 1'b0;
    end else begin
      payload_en_reg <= synced && i_payload_req && (state_reg != ST_EMIT);
    end
  end

  // read data stands one cycle only
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_reg.rd) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      case (i_reg.addr)
        OFF_CTRL:    rdata_reg <= 32'({ofdm_reg, bw_reg, long_reg, 1'b0});
        OFF_CODE:    rdata_reg <= 32'(code_sel_reg);
        OFF_ALLOC:   rdata_reg <= {5'h00, nsub_reg, sub_list_reg[3], sub_list_reg[2],
                                   sub_list_reg[1], sub_list_reg[0]};
        OFF_SHORT:   rdata_reg <= 32'({short_ent_reg, 1'b0, short_sym_reg});
        OFF_GUARD:   rdata_reg <= 32'(guard_reg);
        OFF_OFFSET:  rdata_reg <= 32'(unsigned'(err_reg));
        OFF_STATUS:  rdata_reg <= 32'({code_idx_reg, 3'h0, done_reg, reject_reg,
                                       timing_ok_reg, synced, busy});
        OFF_ADVANCE: rdata_reg <= 32'(unsigned'(advance_reg));
        default:     rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign o_reg_rdata  = rdata_reg;
  assign o_payload_en = payload_en_reg;
  assign o_sample     = sample_reg;
  assign o_phase_cont = sample_reg.valid && sample_reg.second;
  assign o_burst_req  = (state_reg == ST_BURST);
  assign o_ext_header = (state_reg == ST_BURST);
  assign o_tx_advance = advance_reg;
  assign o_timing_ok  = timing_ok_reg;

endmodule
